// ==== design/cfg_access_defs.svh ====
// constants for the configuration-mode unlock and access block
// assumes a 10-bit host i/o address and 8-bit data path
// Functional notes
// - two back-to-back writes of 55h to config_index_select unlock configuration mode.
// - any other write between the two unlock writes restarts the sequence.
// - sixteen 8-bit configuration registers selected by a 4-bit index.
// - in config mode, writing 0 to F at 3F0h loads the index.
// - in config mode, 3F1h reads and writes the indexed register.
// - writing AAh to 3F0h leaves config mode; registers become unreachable.
// - after power-up all options hold defaults and the mode is locked.
// - index port works only in config mode; load it before data access.
// - registers load defaults only at power-up, never on system reset.
`ifndef CFG_ACCESS_DEFS_SVH
`define CFG_ACCESS_DEFS_SVH
`define CFG_INDEX_PORT 10'h3F0
`define CFG_DATA_PORT 10'h3F1
`define CFG_UNLOCK_KEY 8'h55
`define CFG_EXIT_KEY 8'hAA
`define CFG_REG_COUNT 16
`define CFG_INDEX_LSB 0
`define CFG_INDEX_MSB 3
`define CFG_INDEX_RESET 4'h0
`define CFG_DEF_0 8'h3B
`define CFG_DEF_1 8'h9F
`define CFG_DEF_2 8'hDC
`define CFG_DEF_3 8'h78
`define CFG_DEF_4 8'h00
`define CFG_DEF_5 8'h00
`define CFG_DEF_6 8'hFF
`define CFG_DEF_7 8'h00
`define CFG_DEF_8 8'h00
`define CFG_DEF_9 8'h00
`define CFG_DEF_A 8'h00
`define CFG_DEF_B 8'h00
`define CFG_DEF_C 8'h00
`define CFG_DEF_D 8'h66
`define CFG_DEF_E 8'h01
`define CFG_DEF_F 8'h00
`endif

// ==== design/cfg_access_pkg.sv ====
// types for the configuration-mode unlock and access block
// assumes cfg_access_defs.svh supplies the numbers
package cfg_access_pkg;
    typedef enum logic [1:0] {
        LOCKED = 2'b00,
        HALF_KEY = 2'b01,
        UNLOCKED = 2'b10
    } cfg_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
        logic drive;
    } host_rsp_t;
endpackage : cfg_access_pkg

// ==== design/cfg_reg_bank.sv ====
// sixteen configuration registers with power-up defaults
// assumes one write strobe per cycle; por loads defaults, system reset does not
`timescale 1ns/1ps
`include "cfg_access_defs.svh"
module cfg_reg_bank (
    input wire logic clk,
    input wire logic por,
    input wire logic we,
    input wire logic [3:0] idx,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic [`CFG_REG_COUNT*8-1:0] regs_flat
);
    import cfg_access_pkg::*;

    localparam logic [`CFG_REG_COUNT*8-1:0] DEFAULTS = {
        `CFG_DEF_F, `CFG_DEF_E, `CFG_DEF_D, `CFG_DEF_C,
        `CFG_DEF_B, `CFG_DEF_A, `CFG_DEF_9, `CFG_DEF_8,
        `CFG_DEF_7, `CFG_DEF_6, `CFG_DEF_5, `CFG_DEF_4,
        `CFG_DEF_3, `CFG_DEF_2, `CFG_DEF_1, `CFG_DEF_0};

    typedef struct packed {
        logic [`CFG_REG_COUNT*8-1:0] mem;
    } bank_state_t;

    bank_state_t s_q;
    bank_state_t s_d;

    always_comb begin
        s_d = s_q;
        for (int i = 0; i < `CFG_REG_COUNT; i++) begin
            if (we && idx == 4'(i)) begin
                s_d.mem[i*8 +: 8] = wdata;
            end
        end
    end

    // only power-on restores defaults; the bus reset is not wired here
    always_ff @(posedge clk) begin
        if (por) begin
            s_q.mem <= DEFAULTS;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.mem[idx*8 +: 8];
    assign regs_flat = s_q.mem;

    a_default_load: assert property (@(posedge clk) por |=> regs_flat == DEFAULTS)
        else $error("defaults not loaded at power-up");
endmodule : cfg_reg_bank

// ==== design/cfg_mode_access.sv ====
// configuration unlock state machine, index register and data window
// assumes host strobes already synchronised to clk, one cycle per access
`timescale 1ns/1ps
`include "cfg_access_defs.svh"
module cfg_mode_access (
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    input wire cfg_access_pkg::host_req_t req,
    output cfg_access_pkg::host_rsp_t rsp,
    output logic cfg_mode,
    output logic [`CFG_REG_COUNT*8-1:0] config_regs_zero_to_fifteen
);
    import cfg_access_pkg::*;

    typedef struct packed {
        cfg_mode_t mode;
        logic [3:0] config_index_register;
        logic [7:0] rdata;
        logic rvalid;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;
    logic idx_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] bank_rdata;
    logic [7:0] sel_reg;

    function automatic logic hit(input host_req_t r, input logic [9:0] port);
        hit = r.addr == port;
    endfunction : hit

    always_comb begin
        idx_wr = req.wr && hit(req, `CFG_INDEX_PORT);
        // a write caught during the bus reset is dropped, so the reset never alters the bank
        data_wr = req.wr && hit(req, `CFG_DATA_PORT) && s_q.mode == UNLOCKED
            && !rst;
        data_rd = req.rd && hit(req, `CFG_DATA_PORT) && s_q.mode == UNLOCKED;
    end

    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        unique case (s_q.mode)
            LOCKED: begin
                if (idx_wr && req.wdata == `CFG_UNLOCK_KEY) begin
                    s_d.mode = HALF_KEY;
                end
            end
            HALF_KEY: begin
                // reads and idle cycles leave a half-entered key alone; only a write spoils it
                if (idx_wr && req.wdata == `CFG_UNLOCK_KEY) begin
                    s_d.mode = UNLOCKED;
                end else if (req.wr) begin
                    s_d.mode = LOCKED;
                end
            end
            UNLOCKED: begin
                // the exit key has a nonzero upper nibble, so it is never taken as an index
                if (idx_wr && req.wdata == `CFG_EXIT_KEY) begin
                    s_d.mode = LOCKED;
                end else if (idx_wr && req.wdata[7:4] == 4'h0) begin
                    s_d.config_index_register = req.wdata[`CFG_INDEX_MSB:`CFG_INDEX_LSB];
                end
            end
            default: s_d.mode = LOCKED;
        endcase
        if (data_rd) begin
            s_d.rdata = bank_rdata;
            s_d.rvalid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || por) begin
            s_q.mode <= LOCKED;
            s_q.config_index_register <= `CFG_INDEX_RESET;
            s_q.rdata <= 8'h00;
            s_q.rvalid <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    cfg_reg_bank bank (
        .clk(clk),
        .por(por),
        .we(data_wr),
        .idx(s_q.config_index_register),
        .wdata(req.wdata),
        .rdata(bank_rdata),
        .regs_flat(config_regs_zero_to_fifteen)
    );

    assign cfg_mode = s_q.mode == UNLOCKED;
    assign rsp.rdata = s_q.rdata;
    assign rsp.rvalid = s_q.rvalid;
    assign rsp.drive = s_q.rvalid;
    // byte picked by the current index, kept for the checks below
    assign sel_reg = config_regs_zero_to_fifteen[s_q.config_index_register*8 +: 8];

    // the two keys are separate bus writes, usually with idle or read cycles between,
    // so each step of the unlock is checked on its own rather than as adjacent cycles
    sequence key_write;
        req.wr && req.addr == `CFG_INDEX_PORT && req.wdata == `CFG_UNLOCK_KEY;
    endsequence

    sequence first_key;
        (s_q.mode == LOCKED) ##0 key_write;
    endsequence

    sequence second_key;
        (s_q.mode == HALF_KEY) ##0 key_write;
    endsequence

    sequence stray_write;
        s_q.mode == HALF_KEY && req.wr && !(idx_wr && req.wdata == `CFG_UNLOCK_KEY);
    endsequence

    sequence exit_write;
        cfg_mode && idx_wr && req.wdata == `CFG_EXIT_KEY;
    endsequence

    sequence index_write;
        cfg_mode && idx_wr && req.wdata[7:4] == 4'h0;
    endsequence

    sequence window_read;
        cfg_mode && req.rd && req.addr == `CFG_DATA_PORT;
    endsequence

    // unlock and exit
    a_first_key: assert property (@(posedge clk) disable iff (rst || por)
        first_key |=> s_q.mode == HALF_KEY)
        else $error("first unlock key not taken");
    a_unlock_two_keys: assert property (@(posedge clk) disable iff (rst || por)
        second_key |=> cfg_mode)
        else $error("two unlock keys did not unlock");
    a_no_skip_key: assert property (@(posedge clk) disable iff (rst || por)
        (s_q.mode == LOCKED) |=> s_q.mode != UNLOCKED)
        else $error("unlocked with a single key");
    a_half_key_holds: assert property (@(posedge clk) disable iff (rst || por)
        (s_q.mode == HALF_KEY && !req.wr) |=> s_q.mode == HALF_KEY)
        else $error("half key lost without a write");
    a_break_restarts: assert property (@(posedge clk) disable iff (rst || por)
        stray_write |=> s_q.mode == LOCKED)
        else $error("intervening write did not break unlock");
    a_exit_locks: assert property (@(posedge clk) disable iff (rst || por)
        exit_write |=> !cfg_mode)
        else $error("exit key did not lock");
    a_exit_keeps_regs: assert property (@(posedge clk) disable iff (rst || por)
        exit_write |=> $stable(config_regs_zero_to_fifteen))
        else $error("exit key altered a register");
    a_unlocked_stays: assert property (@(posedge clk) disable iff (rst || por)
        (cfg_mode && !(idx_wr && req.wdata == `CFG_EXIT_KEY)) |=> cfg_mode)
        else $error("left config mode without exit key");

    // the index moves only on a low-nibble write while unlocked
    a_index_load: assert property (@(posedge clk) disable iff (rst || por)
        index_write |=> {4'h0, s_q.config_index_register} == $past(req.wdata))
        else $error("index not loaded");
    a_high_index_ignored: assert property (@(posedge clk) disable iff (rst || por)
        (cfg_mode && idx_wr && req.wdata[7:4] != 4'h0) |=> $stable(s_q.config_index_register))
        else $error("index took a high-nibble write");
    a_exit_keeps_index: assert property (@(posedge clk) disable iff (rst || por)
        exit_write |=> $stable(s_q.config_index_register))
        else $error("exit key altered the index");
    a_index_locked: assert property (@(posedge clk) disable iff (rst || por)
        (!cfg_mode) |=> $stable(s_q.config_index_register))
        else $error("index changed while locked");
    a_locked_index_write: assert property (@(posedge clk) disable iff (rst || por)
        (!cfg_mode && idx_wr && req.wdata[7:4] == 4'h0) |=> !cfg_mode)
        else $error("index write unlocked the block");

    // a read answers one cycle after its strobe with the byte selected at the strobe
    a_locked_silent: assert property (@(posedge clk) disable iff (rst || por)
        (!cfg_mode && req.rd) |=> !rsp.rvalid)
        else $error("answered read while locked");
    a_locked_no_store: assert property (@(posedge clk) disable iff (rst || por)
        (!cfg_mode) |=> $stable(config_regs_zero_to_fifteen))
        else $error("register written while locked");
    a_drive_unlocked: assert property (@(posedge clk) disable iff (rst || por)
        rsp.drive |-> $past(cfg_mode))
        else $error("bus driven outside config mode");
    a_answer_needs_read: assert property (@(posedge clk) disable iff (rst || por)
        rsp.rvalid |-> $past(data_rd))
        else $error("answer without a window read");
    a_read_answer: assert property (@(posedge clk) disable iff (rst || por)
        window_read |=> rsp.rvalid && rsp.rdata == $past(sel_reg))
        else $error("window read returned wrong byte");
    a_rdata_holds: assert property (@(posedge clk) disable iff (rst || por)
        !data_rd |=> $stable(rsp.rdata))
        else $error("read data changed without a read");
    a_window_write_only: assert property (@(posedge clk) disable iff (rst || por)
        !data_wr |=> $stable(config_regs_zero_to_fifteen))
        else $error("register changed without a window write");
    a_write_reaches: assert property (@(posedge clk) disable iff (rst || por)
        data_wr |=> sel_reg == $past(req.wdata))
        else $error("data write not stored");

    // the bus reset relocks but keeps the bank; only power-up reloads defaults
    a_reset_locks: assert property (@(posedge clk)
        rst |=> !cfg_mode)
        else $error("reset did not lock");
    a_power_locks: assert property (@(posedge clk)
        por |=> !cfg_mode && !rsp.rvalid)
        else $error("power-up did not lock");
    a_power_index: assert property (@(posedge clk)
        por |=> s_q.config_index_register == `CFG_INDEX_RESET)
        else $error("power-up did not clear the index");
    a_reset_keeps_regs: assert property (@(posedge clk) disable iff (por)
        rst |=> $stable(config_regs_zero_to_fifteen))
        else $error("bus reset altered a register");
endmodule : cfg_mode_access

// ==== dv/cfg_host_model.sv ====
// host model: isa-style i/o master issuing one-cycle strobes
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
`include "cfg_access_defs.svh"
module cfg_host_model (
    input wire logic clk,
    output cfg_access_pkg::host_req_t req,
    input wire cfg_access_pkg::host_rsp_t rsp
);
    import cfg_access_pkg::*;
    initial req = '0;
    task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        // a released bus must not keep showing the last byte
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : io_wr
    task automatic io_rd(input logic [9:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hC3};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h3C};
        #1;
        v = rsp.rvalid;
        d = rsp.rdata;
    endtask : io_rd
    task automatic unlock();
        // no other write slips between the keys, as with interrupts held off
        io_wr(`CFG_INDEX_PORT, `CFG_UNLOCK_KEY);
        io_wr(`CFG_INDEX_PORT, `CFG_UNLOCK_KEY);
    endtask : unlock
    task automatic sel_wr(input logic [3:0] i, input logic [7:0] d);
        io_wr(`CFG_INDEX_PORT, {4'h0, i});
        io_wr(`CFG_DATA_PORT, d);
    endtask : sel_wr
endmodule : cfg_host_model

// ==== dv/config_mode_unlock_access_test.sv ====
// self-checking bench for the configuration unlock and access block
// assumes cfg_access_defs.svh is on the include path
`timescale 1ns/1ps
`include "cfg_access_defs.svh"
module config_mode_unlock_access_test;
    import cfg_access_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    host_req_t req;
    host_rsp_t rsp;
    logic cfg_mode;
    logic [127:0] regs;
    logic [127:0] model;
    logic [7:0] d;
    logic v;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    cfg_host_model i_host (.clk(clk), .req(req), .rsp(rsp));
    cfg_mode_access i_dut (.clk(clk), .rst(rst), .por(por), .req(req), .rsp(rsp),
        .cfg_mode(cfg_mode), .config_regs_zero_to_fifteen(regs));
    function automatic logic [127:0] defaults();
        return {`CFG_DEF_F, `CFG_DEF_E, `CFG_DEF_D, `CFG_DEF_C, `CFG_DEF_B, `CFG_DEF_A,
            `CFG_DEF_9, `CFG_DEF_8, `CFG_DEF_7, `CFG_DEF_6, `CFG_DEF_5, `CFG_DEF_4,
            `CFG_DEF_3, `CFG_DEF_2, `CFG_DEF_1, `CFG_DEF_0};
    endfunction : defaults
    task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        model = defaults();
        void'($urandom(32'h2C15));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge clk);
        #1;
        chk("defaults", model, regs);
        chk("mode after power-up", 0, cfg_mode);
        i_host.io_wr(`CFG_DATA_PORT, 8'h5A);
        i_host.io_rd(`CFG_DATA_PORT, d, v);
        chk("locked rvalid", 0, v);
        chk("locked drive", 0, rsp.drive);
        chk("locked regs", model, regs);
        $display("test locked done");
        i_host.io_wr(`CFG_INDEX_PORT, `CFG_UNLOCK_KEY);
        i_host.io_wr(`CFG_DATA_PORT, `CFG_UNLOCK_KEY);
        i_host.io_wr(`CFG_INDEX_PORT, `CFG_UNLOCK_KEY);
        #1;
        chk("broken key", 0, cfg_mode);
        i_host.io_wr(`CFG_INDEX_PORT, 8'h00);
        #1;
        chk("locked index", 0, cfg_mode);
        i_host.unlock();
        #1;
        chk("unlocked", 1, cfg_mode);
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom);
            model[8*i+:8] = d;
            i_host.sel_wr(4'(i), d);
        end
        #1;
        chk("bank written", model, regs);
        for (int i = 15; i >= 0; i--) begin
            i_host.io_wr(`CFG_INDEX_PORT, 8'(i));
            i_host.io_rd(`CFG_DATA_PORT, d, v);
            chk("read valid", 1, v);
            chk("read drive", 1, rsp.drive);
            chk("read data", model[8*i+:8], d);
        end
        i_host.io_wr(`CFG_INDEX_PORT, 8'h12);
        i_host.io_rd(`CFG_DATA_PORT, d, v);
        chk("index out of range", model[7:0], d);
        $display("test access done");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("regs kept on reset", model, regs);
        chk("mode after reset", 0, cfg_mode);
        i_host.unlock();
        #1;
        chk("unlocked again", 1, cfg_mode);
        i_host.io_wr(`CFG_INDEX_PORT, `CFG_EXIT_KEY);
        #1;
        chk("exit key", 0, cfg_mode);
        i_host.io_wr(`CFG_DATA_PORT, 8'hE7);
        i_host.io_rd(`CFG_DATA_PORT, d, v);
        chk("after exit rvalid", 0, v);
        chk("after exit regs", model, regs);
        $display("test exit done");
        test_done();
    end
endmodule : config_mode_unlock_access_test
